// ---- fmc2_pkg.sv ----
/*
 fmc2_pkg: constants and carrier types for the second configuration register
 of the fan monitor.
 Assumes: an outer serial slave decodes the register offset and hands over
 byte writes and reads on the system clock.
*/
package fmc2_pkg;
	localparam logic [7:0] FMC2_CFG2_OFFSET = 8'h01;
	localparam logic [7:0] FMC2_CFG2_RESET = 8'h3D;
	localparam int FMC2_BIT_SOFT_RESET = 7;
	localparam int FMC2_BIT_SUPPLY_IE = 6;
	localparam int FMC2_BIT_REMOTE_IE = 5;
	localparam int FMC2_BIT_LOCAL_IE = 4;
	localparam int FMC2_BIT_FAIL_IE = 3;
	localparam int FMC2_BIT_SPEED_EN = 2;
	localparam int FMC2_BIT_MEAS_MODE = 1;
	localparam int FMC2_BIT_PWM_EN = 0;
	localparam logic [1:0] FMC2_DRIVE_SW_SPEED = 2'b01;
	// duty thresholds on an 8-bit scale, 255 = 100%
	localparam int FMC2_DUTY_FULL = 255;
	localparam int FMC2_FLOOR_PCT = 30;
	localparam int FMC2_CUTOFF_PCT = 7;
	localparam logic [7:0] FMC2_DUTY_FLOOR = 8'((FMC2_FLOOR_PCT * FMC2_DUTY_FULL + 99) / 100);
	localparam logic [7:0] FMC2_DUTY_CUTOFF = 8'((FMC2_CUTOFF_PCT * FMC2_DUTY_FULL + 99) / 100);
	localparam logic [7:0] FMC2_DUTY_ZERO = 8'h00;
	localparam int FMC2_SOFT_RESET_CYCLES = 4;
	localparam logic [7:0] FMC2_PWM_MAX = 8'hFF;

	typedef struct packed {
		logic supply_alarm_flag;
		logic remote_overtemp_flag;
		logic local_overtemp_flag;
		logic sensor_failure_flag;
	} fmc2_flags_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fmc2_bus_req_t;
endpackage : fmc2_pkg

// ---- fmc2_duty_shaper.sv ----
/*
 fmc2_duty_shaper: applies the low-duty floor or cutoff and turns the
 shaped duty into a free-running pwm waveform.
 Assumes: duty and mode inputs are on sys_clk_i; reset synchronous.
*/
`timescale 1ns/10ps
module fmc2_duty_shaper
	import fmc2_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] duty_i,
	input wire logic sw_speed_mode_i,
	input wire logic measure_mode_i,
	input wire logic force_on_i,
	output logic [7:0] shaped_o,
	output logic pwm_o
);
	logic [7:0] cnt_reg, cnt_next;
	logic [7:0] shaped_reg, shaped_next;
	logic pwm_reg, pwm_next;

	always_comb
	begin
		cnt_next = (cnt_reg == FMC2_PWM_MAX) ? 8'h00 : 8'(cnt_reg + 8'h01);
		if (!measure_mode_i && sw_speed_mode_i && duty_i < FMC2_DUTY_FLOOR)
			shaped_next = FMC2_DUTY_FLOOR; // [R12]
		else if (!(sw_speed_mode_i && !measure_mode_i) && duty_i < FMC2_DUTY_CUTOFF)
			shaped_next = FMC2_DUTY_ZERO; // [R13]
		else
			shaped_next = duty_i; // [R14]
		// forcing only with mode zero; mode one follows duty, cut to zero below the cutoff
		pwm_next = (force_on_i && !measure_mode_i) || (cnt_reg < shaped_reg); // [R11] [R14]
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			cnt_reg <= 8'h00;
			shaped_reg <= 8'h00;
			pwm_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			shaped_reg <= shaped_next;
			pwm_reg <= pwm_next;
		end
	end

	assign shaped_o = shaped_reg;
	assign pwm_o = pwm_reg;

	a_floor_applied: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(sw_speed_mode_i && !measure_mode_i && duty_i < FMC2_DUTY_FLOOR)
		|=> shaped_reg == FMC2_DUTY_FLOOR) // [R12]
		else $error("duty floor not applied");
	a_cutoff_applied: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!sw_speed_mode_i && duty_i < FMC2_DUTY_CUTOFF) |=> shaped_reg == 8'h00) // [R13]
		else $error("duty cutoff not applied");
	a_mode_one_exact: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(measure_mode_i && duty_i >= FMC2_DUTY_CUTOFF) |=> shaped_reg == $past(duty_i)) // [R14]
		else $error("duty altered in mode one");
endmodule : fmc2_duty_shaper

// ---- fmc2_config_two.sv ----
/*
 fmc2_config_two: second configuration register of the fan monitor with
 alert gating, speed input gating and pwm output control.
 Assumes: the serial slave presents byte writes as a one-cycle request on
 sys_clk_i and raises soft_strobe_i at the data lsb clock edge of a write
 with bit 7 set, suppressing the acknowledge itself.
*/
//
// Overview of operation
// [R1] register at 0x01 resets to 0x3D
// [R2] bit 7 resets device, reads zero
// [R3] soft reset acts at data lsb edge
// [R4] bit 6 gates supply alarm interrupt
// [R5] bit 5 gates remote overtemp interrupt
// [R6] remote enable cleared if sensor failed
// [R7] bit 4 gates local overtemp interrupt
// [R8] bit 3 gates sensor failure alert
// [R9] bit 2 clear freezes speed counter
// [R10] host sets mode when disabling input
// [R11] mode zero forces pwm during measurement
// [R12] software speed mode floors duty 30%
// [R13] other modes cut duty below 7%
// [R14] mode one follows duty exactly; code still cuts duty below 7% to zero in mode one
// [R15] host sets mode for dc fans
// [R16] bit 0 clear tristates pwm pin
// [R17] drive select 01 is software speed
// [R18] enabled interrupts drive the alert pin
// [R19] global alert enable needed first
// [R20] alert when flag, enable, global set
// [R21] soft reset restores registers, restarts measurement
`timescale 1ns/10ps
module fmc2_config_two
	import fmc2_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire fmc2_pkg::fmc2_bus_req_t bus_req_i,
	input wire logic soft_strobe_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	input wire fmc2_pkg::fmc2_flags_t flags_i,
	input wire logic global_alert_enable_i,
	input wire logic fan_drive_select_high_i,
	input wire logic fan_drive_select_low_i,
	input wire logic [7:0] duty_cycle_setting_i,
	input wire logic fan_speed_pulse_input_i,
	input wire logic measure_window_i,
	output logic alert_n_o,
	output logic alert_n_oe_o,
	output logic pwm_out_o,
	output logic pwm_out_oe_o,
	output logic [15:0] speed_count_o,
	output logic device_reset_o
);
	logic [7:0] cfg_reg, cfg_next;
	logic [2:0] soft_cnt_reg, soft_cnt_next;
	logic soft_active;
	logic por_seen_reg, por_seen_next;
	logic [1:0] pulse_sync_reg, pulse_sync_next;
	logic pulse_prev_reg, pulse_prev_next;
	logic [15:0] speed_reg, speed_next;
	logic alert_reg, alert_next;
	logic pwm_reg, pwm_next;
	logic pwm_oe_reg, pwm_oe_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic dev_rst_reg, dev_rst_next;
	logic [3:0] gated;
	logic sw_speed;
	logic shaper_rst_n;
	logic shaper_pwm;
	logic [7:0] shaped_duty;

	assign soft_active = soft_cnt_reg != 3'd0;
	assign shaper_rst_n = rst_n_i && !soft_active; // [R21]
	assign sw_speed = {fan_drive_select_high_i, fan_drive_select_low_i}
		== FMC2_DRIVE_SW_SPEED; // [R17]

	// soft reset sequencing and the register itself
	always_comb
	begin
		cfg_next = cfg_reg;
		soft_cnt_next = soft_active ? 3'(soft_cnt_reg - 3'd1) : 3'd0;
		por_seen_next = 1'b1;
		if (soft_strobe_i)
		begin
			// acts immediately; write data below is discarded
			soft_cnt_next = 3'(FMC2_SOFT_RESET_CYCLES); // [R3]
			cfg_next = FMC2_CFG2_RESET; // [R21]
		end
		else if (soft_active)
			cfg_next = FMC2_CFG2_RESET; // [R2]
		else if (bus_req_i.wr_en && bus_req_i.addr == FMC2_CFG2_OFFSET)
		begin
			cfg_next = bus_req_i.wdata;
			cfg_next[FMC2_BIT_SOFT_RESET] = 1'b0; // [R2]
		end
		// strap-like capture one cycle after release
		if (!por_seen_reg && flags_i.sensor_failure_flag)
			cfg_next[FMC2_BIT_REMOTE_IE] = 1'b0; // [R6]
		dev_rst_next = soft_strobe_i || soft_active; // [R2]
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			cfg_reg <= FMC2_CFG2_RESET; // [R1]
			soft_cnt_reg <= 3'd0;
			por_seen_reg <= 1'b0;
			dev_rst_reg <= 1'b0;
		end
		else
		begin
			cfg_reg <= cfg_next;
			soft_cnt_reg <= soft_cnt_next;
			por_seen_reg <= por_seen_next;
			dev_rst_reg <= dev_rst_next;
		end
	end

	// read port
	always_comb
	begin
		rvalid_next = bus_req_i.rd_en;
		rdata_next = 8'h00;
		if (bus_req_i.rd_en && bus_req_i.addr == FMC2_CFG2_OFFSET)
		begin
			rdata_next = cfg_reg;
			rdata_next[FMC2_BIT_SOFT_RESET] = 1'b0; // [R2]
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// alert gating, one enable per source
	assign gated[3] = flags_i.supply_alarm_flag && cfg_reg[FMC2_BIT_SUPPLY_IE]; // [R4]
	assign gated[2] = flags_i.remote_overtemp_flag && cfg_reg[FMC2_BIT_REMOTE_IE]; // [R5]
	assign gated[1] = flags_i.local_overtemp_flag && cfg_reg[FMC2_BIT_LOCAL_IE]; // [R7]
	assign gated[0] = flags_i.sensor_failure_flag && cfg_reg[FMC2_BIT_FAIL_IE]; // [R8]

	always_comb
	begin
		// global enable gates all sources together
		alert_next = global_alert_enable_i && (|gated) && !soft_active; // [R18] [R19] [R20]
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			alert_reg <= 1'b0;
		else
			alert_reg <= alert_next;
	end

	// speed pulse input: pin, so two flops before use
	always_comb
	begin
		pulse_sync_next = {pulse_sync_reg[0], fan_speed_pulse_input_i};
		pulse_prev_next = pulse_sync_reg[1];
		speed_next = speed_reg;
		if (cfg_reg[FMC2_BIT_SPEED_EN] && pulse_sync_reg[1] && !pulse_prev_reg)
			speed_next = 16'(speed_reg + 16'h0001); // [R9]
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!shaper_rst_n)
		begin
			pulse_sync_reg <= 2'b00;
			pulse_prev_reg <= 1'b0;
			speed_reg <= 16'h0000; // [R21]
		end
		else
		begin
			pulse_sync_reg <= pulse_sync_next;
			pulse_prev_reg <= pulse_prev_next;
			speed_reg <= speed_next;
		end
	end

	fmc2_duty_shaper u_shaper (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(shaper_rst_n),
		.duty_i(duty_cycle_setting_i),
		.sw_speed_mode_i(sw_speed),
		.measure_mode_i(cfg_reg[FMC2_BIT_MEAS_MODE]),
		.force_on_i(measure_window_i),
		.shaped_o(shaped_duty),
		.pwm_o(shaper_pwm)
	);

	// pin driver; released pin floats
	always_comb
	begin
		pwm_next = shaper_pwm;
		pwm_oe_next = cfg_reg[FMC2_BIT_PWM_EN]; // [R16]
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			pwm_reg <= 1'b0;
			pwm_oe_reg <= 1'b0;
		end
		else
		begin
			pwm_reg <= pwm_next;
			pwm_oe_reg <= pwm_oe_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign rvalid_o = rvalid_reg;
	assign alert_n_o = 1'b0;
	assign alert_n_oe_o = alert_reg;
	assign pwm_out_o = pwm_reg;
	assign pwm_out_oe_o = pwm_oe_reg;
	assign speed_count_o = speed_reg;
	assign device_reset_o = dev_rst_reg;

	a_reset_value: assert property (@(posedge sys_clk_i)
		(!rst_n_i) |=> cfg_reg == FMC2_CFG2_RESET) // [R1]
		else $error("config two reset value wrong");
	a_soft_reads_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		rvalid_reg |-> !rdata_reg[FMC2_BIT_SOFT_RESET]) // [R2]
		else $error("soft reset bit read as one");
	a_soft_immediate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		soft_strobe_i |=> device_reset_o && cfg_reg == FMC2_CFG2_RESET ##5 !device_reset_o) // [R3]
		else $error("soft reset not immediate or not self clearing");
	a_alert_gated: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(global_alert_enable_i && flags_i.supply_alarm_flag && cfg_reg[FMC2_BIT_SUPPLY_IE]
		&& !soft_active) |=> alert_n_oe_o) // [R4]
		else $error("supply alarm did not raise alert");
	a_alert_blocked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!global_alert_enable_i || (gated == 4'h0)) |=> !alert_n_oe_o) // [R19] [R20]
		else $error("alert raised without enabled source");
	a_local_gated: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(global_alert_enable_i && flags_i.local_overtemp_flag && cfg_reg[FMC2_BIT_LOCAL_IE]
		&& !soft_active) |=> alert_n_oe_o) // [R7]
		else $error("local overtemp did not raise alert");
	a_speed_frozen: assert property (@(posedge sys_clk_i) disable iff (!shaper_rst_n)
		(!cfg_reg[FMC2_BIT_SPEED_EN] && !soft_strobe_i) |=> $stable(speed_reg)) // [R9]
		else $error("speed counter moved while disabled");
	a_pwm_tristate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!cfg_reg[FMC2_BIT_PWM_EN]) |=> !pwm_out_oe_o) // [R16]
		else $error("pwm pin driven while disabled");
	a_force_on: assert property (@(posedge sys_clk_i) disable iff (!shaper_rst_n)
		(measure_window_i && !cfg_reg[FMC2_BIT_MEAS_MODE] && !soft_strobe_i)
		|=> ##1 pwm_out_o) // [R11]
		else $error("pwm not forced on during measurement");
endmodule : fmc2_config_two

// ---- fmc2_host_model.sv ----
/*
 fmc2_host_model: host side serial master that issues byte requests
 to the second configuration register.
 Assumes: requests change on the falling edge of sys_clk_i.
*/
`timescale 1ns/10ps
module fmc2_host_model
	import fmc2_pkg::*;
#(
	parameter bit DC_FAN = 1'b0
)
(
	input wire logic sys_clk_i,
	output fmc2_pkg::fmc2_bus_req_t bus_req_o,
	output logic soft_strobe_o
);
	initial
	begin
		bus_req_o = '0;
		soft_strobe_o = 1'b0;
	end

	task automatic put(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] d;
		logic hit;
		d = data;
		hit = wr && addr == FMC2_CFG2_OFFSET;
		// an ignored speed input must not keep forcing the pwm on
		if (hit && !d[FMC2_BIT_SPEED_EN])
			d[FMC2_BIT_MEAS_MODE] = 1'b1;
		if (hit && DC_FAN)
			d[FMC2_BIT_MEAS_MODE] = 1'b1;
		@(negedge sys_clk_i);
		bus_req_o <= '{wr_en: wr, rd_en: !wr, addr: addr, wdata: d};
		soft_strobe_o <= hit && d[FMC2_BIT_SOFT_RESET];
		@(negedge sys_clk_i);
		bus_req_o <= '0;
		soft_strobe_o <= 1'b0;
	endtask : put
endmodule : fmc2_host_model

// ---- fan_monitor_control_config_two_test.sv ----
/*
 fan_monitor_control_config_two_test: self-checking bench of the register.
 Assumes: pwm period at most 256 cycles; inputs move on falling edges.
*/
`timescale 1ns/10ps
module fan_monitor_control_config_two_test;
	import fmc2_pkg::*;
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin failures++; \
	$display("Error %s expected %h seen %h", nm, ex, sn); end end
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	fmc2_bus_req_t bus_req;
	logic soft_strobe;
	fmc2_flags_t flags = '0;
	logic gae = 1'b0, fsh = 1'b0, fsl = 1'b0, pulse = 1'b0, meas = 1'b0;
	logic [7:0] duty = 8'h00, rdata, lfsr = 8'h60;
	logic rvalid, alert_n, alert_oe, pwm, pwm_oe, dev_rst;
	logic [15:0] cnt, n0;
	int failures = 0, compares = 0, h;
	localparam logic [7:0] OFS = FMC2_CFG2_OFFSET;

	always #20 sys_clk_i = ~sys_clk_i;

	fmc2_host_model host (.sys_clk_i(sys_clk_i), .bus_req_o(bus_req), .soft_strobe_o(soft_strobe));
	fmc2_config_two DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req),
		.soft_strobe_i(soft_strobe), .rdata_o(rdata), .rvalid_o(rvalid), .flags_i(flags),
		.global_alert_enable_i(gae), .fan_drive_select_high_i(fsh),
		.fan_drive_select_low_i(fsl), .duty_cycle_setting_i(duty),
		.fan_speed_pulse_input_i(pulse), .measure_window_i(meas), .alert_n_o(alert_n),
		.alert_n_oe_o(alert_oe), .pwm_out_o(pwm), .pwm_out_oe_o(pwm_oe),
		.speed_count_o(cnt), .device_reset_o(dev_rst));

	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr_next

	function automatic logic [7:0] exp_cfg(input logic [7:0] d);
		logic [7:0] e;
		e = d & 8'h7F;
		if (!e[FMC2_BIT_SPEED_EN])
			e[FMC2_BIT_MEAS_MODE] = 1'b1;
		return e;
	endfunction : exp_cfg

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : cyc

	task automatic do_reset();
		rst_n_i = 1'b0;
		cyc(12);
		rst_n_i = 1'b1;
		cyc(2);
	endtask : do_reset

	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		host.put(1'b0, a, 8'h00);
		`CHK("rvalid", 1'b1, rvalid)
		`CHK("rdata", ex, rdata)
	endtask : rd

	task automatic pulses(input int n);
		repeat (n)
		begin
			pulse = 1'b1;
			cyc(4);
			pulse = 1'b0;
			cyc(4);
		end
	endtask : pulses

	// counting highs rather than edges, since period is not pinned down
	task automatic highs(output int c);
		c = 0;
		repeat (520)
		begin
			cyc(1);
			c += int'(pwm === 1'b1);
		end
	endtask : highs

	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#(40 * 30000);
		failures++;
		tally_and_finish();
	end

	initial
	begin
		do_reset();
		rd(OFS, FMC2_CFG2_RESET);
		`CHK("pwm_oe", 1'b1, pwm_oe)
		rd(8'h02, 8'h00);
		repeat (20)
		begin
			lfsr = lfsr_next(lfsr);
			host.put(1'b1, OFS, lfsr & 8'h7F);
			rd(OFS, exp_cfg(lfsr));
			`CHK("pwm_oe", lfsr[0], pwm_oe)
		end
		gae = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			host.put(1'b1, OFS, 8'h04 | (8'h40 >> i));
			flags = 4'h8 >> i;
			cyc(3);
			`CHK("alert_on", 1'b1, alert_oe)
			host.put(1'b1, OFS, 8'h7C ^ (8'h40 >> i));
			cyc(2);
			`CHK("alert_masked", 1'b0, alert_oe)
			flags = '0;
		end
		host.put(1'b1, OFS, 8'h7D);
		flags = 4'hF;
		gae = 1'b0;
		cyc(3);
		`CHK("alert_global", 1'b0, alert_oe)
		gae = 1'b1;
		cyc(3);
		`CHK("alert_all", 1'b1, alert_oe)
		`CHK("alert_level", 1'b0, alert_n)
		flags = '0;
		n0 = cnt;
		pulses(3);
		`CHK("speed_count", n0 + 16'd3, cnt)
		host.put(1'b1, OFS, 8'h39);
		n0 = cnt;
		pulses(3);
		`CHK("speed_frozen", n0, cnt)
		rd(OFS, 8'h3B);
		host.put(1'b1, OFS, 8'h3D);
		meas = 1'b1;
		cyc(4);
		`CHK("pwm_forced", 1'b1, pwm)
		host.put(1'b1, OFS, 8'h3F);
		cyc(4);
		`CHK("pwm_follow", 1'b0, pwm)
		meas = 1'b0;
		duty = 8'h11;
		fsl = 1'b1;
		highs(h);
		`CHK("pwm_cut_mode1", 1'b1, h == 0)
		host.put(1'b1, OFS, 8'h3D);
		highs(h);
		// two full periods at the floor, a few samples lost to pipeline latency
		`CHK("pwm_floor", 1'b1, h >= 2 * int'(FMC2_DUTY_FLOOR) - 4 && h <= 2 * int'(FMC2_DUTY_FLOOR) + 8)
		fsh = 1'b1;
		highs(h);
		`CHK("pwm_cut_11", 1'b1, h == 0)
		fsl = 1'b0;
		highs(h);
		`CHK("pwm_cut_10", 1'b1, h == 0)
		fsh = 1'b0;
		highs(h);
		`CHK("pwm_cut", 1'b1, h == 0)
		host.put(1'b1, OFS, 8'hBF);
		`CHK("dev_rst_on", 1'b1, dev_rst)
		cyc(6);
		`CHK("dev_rst_off", 1'b0, dev_rst)
		`CHK("speed_reset", 16'h0000, cnt)
		rd(OFS, FMC2_CFG2_RESET);
		flags = 4'h1;
		do_reset();
		flags = '0;
		rd(OFS, 8'h1D);
		tally_and_finish();
	end
endmodule : fan_monitor_control_config_two_test
